// [core/sad_pkg.sv]
// package: constants and types for the storage addressing datapath slice
package sad_pkg;
	// data, byte and sign extension source widths
	localparam int unsigned DATA_W    = 16;
	localparam int unsigned BYTE_W    = 8;
	localparam int unsigned SEXT_FROM = 8;
	// register offsets on the register port
	localparam logic [7:0] REG_LSR = 8'h00;
	localparam logic [7:0] REG_PSW = 8'h04;
	localparam logic [7:0] REG_SAR = 8'h08;
	localparam logic [7:0] REG_CFG = 8'h0c;
	// level status register indicators, bit 0 is the leftmost bit
	localparam int unsigned LSR_EVEN  = 15;
	localparam int unsigned LSR_CARRY = 14;
	localparam int unsigned LSR_OVF   = 13;
	localparam int unsigned LSR_NEG   = 12;
	localparam int unsigned LSR_ZERO  = 11;
	localparam logic [15:0] LSR_MASK  = 16'hf800;
	localparam logic [15:0] LSR_RESET = 16'h0000;
	// processor status word: specification check and storage parity
	localparam int unsigned PSW_SPEC  = 14;
	localparam int unsigned PSW_PAR   = 13;
	localparam logic [15:0] PSW_MASK  = 16'h6000;
	localparam logic [15:0] PSW_RESET = 16'h0000;
	// configuration: parity checking enable
	localparam int unsigned CFG_PAR_EN = 0;
	localparam logic [15:0] CFG_MASK   = 16'h0001;
	localparam logic [15:0] CFG_RESET  = 16'h0001;
	// index of the last byte of each operand size
	localparam logic [1:0] LAST_BYTE = 2'h0;
	localparam logic [1:0] LAST_WORD = 2'h1;
	localparam logic [1:0] LAST_DBL  = 2'h3;
	localparam logic [15:0] ADDR_STEP = 16'h0001;
	// datapath operations
	typedef enum logic [4:0] {
		SAD_OP_ADD, SAD_OP_SUB, SAD_OP_AND, SAD_OP_OR, SAD_OP_XOR,
		SAD_OP_MOVE, SAD_OP_CMPL, SAD_OP_SEXT, SAD_OP_ADDR, SAD_OP_BRAN,
		SAD_OP_LDB, SAD_OP_LDW, SAD_OP_LDD, SAD_OP_STB, SAD_OP_STW,
		SAD_OP_STD, SAD_OP_BTST
	} sad_op_t;
	// alu functions
	typedef enum logic [2:0] {
		SAD_ALU_ADD, SAD_ALU_SUB, SAD_ALU_AND, SAD_ALU_OR,
		SAD_ALU_XOR, SAD_ALU_PASS, SAD_ALU_NEG, SAD_ALU_SEXT
	} sad_alu_t;
	// sequencer states
	typedef enum logic [1:0] {
		SAD_ST_IDLE, SAD_ST_ISSUE, SAD_ST_CAPT
	} sad_state_t;
endpackage

// [core/sad_alu.sv]
// file: combinational arithmetic and logic unit with indicator outputs
`timescale 1ns/10ps
module sad_alu #(
	parameter int unsigned WIDTH = sad_pkg::DATA_W
) (
	// function and operands
	input  wire sad_pkg::sad_alu_t i_func,
	input  wire logic [WIDTH-1:0]  i_a,
	input  wire logic [WIDTH-1:0]  i_b,
	// result and indicators
	output logic [WIDTH-1:0]       o_y,
	output logic                   o_carry,
	output logic                   o_ovf,
	output logic                   o_even,
	output logic                   o_neg,
	output logic                   o_zero
);
	localparam logic [WIDTH-1:0] MIN_NEG = {1'b1, {(WIDTH-1){1'b0}}};
	logic [WIDTH:0] sum;

	if (WIDTH <= sad_pkg::SEXT_FROM)
		$error("alu width must exceed the sign extension source");

	always_comb
	begin
		sum     = '0;
		o_y     = '0;
		o_carry = 1'b0;
		o_ovf   = 1'b0;
		case (i_func)
			sad_pkg::SAD_ALU_ADD:
			begin
				sum     = {1'b0, i_a} + {1'b0, i_b};
				o_y     = sum[WIDTH-1:0];
				o_carry = sum[WIDTH];
				o_ovf   = (i_a[WIDTH-1] == i_b[WIDTH-1]) && (o_y[WIDTH-1] != i_a[WIDTH-1]);
			end
			sad_pkg::SAD_ALU_SUB:
			begin
				// carry here means borrow, the unsigned overflow of a subtract
				sum     = {1'b0, i_a} - {1'b0, i_b};
				o_y     = sum[WIDTH-1:0];
				o_carry = sum[WIDTH];
				o_ovf   = (i_a[WIDTH-1] != i_b[WIDTH-1]) && (o_y[WIDTH-1] != i_a[WIDTH-1]);
			end
			sad_pkg::SAD_ALU_AND:  o_y = i_a & i_b;
			sad_pkg::SAD_ALU_OR:   o_y = i_a | i_b;
			sad_pkg::SAD_ALU_XOR:  o_y = i_a ^ i_b;
			sad_pkg::SAD_ALU_PASS: o_y = i_a;
			sad_pkg::SAD_ALU_NEG:
			begin
				o_y   = WIDTH'(~i_a + 1'b1);
				o_ovf = (i_a == MIN_NEG);
			end
			sad_pkg::SAD_ALU_SEXT:
				o_y = {{(WIDTH-sad_pkg::SEXT_FROM){i_a[sad_pkg::SEXT_FROM-1]}},
					i_a[sad_pkg::SEXT_FROM-1:0]};
			default: o_y = '0;
		endcase
		o_even = ~o_y[0];
		o_neg  = o_y[WIDTH-1];
		o_zero = (o_y == '0);
	end
endmodule // sad_alu

// [core/sad_core.sv]
// file: storage addressing, alignment checking and alu datapath slice
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/10ps
// Function
// - odd byte parity; even parity is machine check
// - bit 0 is leftmost, continues next byte
// - word two bytes, doubleword four, even start
// - 16-bit unsigned byte address from zero
// - addresses wrap modulo 65536
// - word and doubleword addresses must be even
// - operand address selects most significant byte
// - bit operand: byte address plus displacement
// - word displacement base register must be even
// - branch targets must be even
// - misalignment ends instruction, sets specification check
// - alu adds, subtracts, ands, ors, xors
// - alu also forms operand and branch addresses
// - add and subtract have no signed mode
// - two's complement, high bit is sign
// - widening copies the sign bit
// - add and subtract update carry and overflow
// - indicators sit in status bits 0-4
// - carry flags unsigned overflow
// - even, negative, zero follow last result; LDD, BTST, stores, ADDR and BRAN leave them as they were
// - complementing most negative sets overflow
module sad_core (
	// clock and reset
	input  wire logic             i_clock,
	input  wire logic             i_nrst,
	// register port
	input  wire logic [7:0]       i_reg_addr,
	input  wire logic [15:0]      i_reg_wdata,
	input  wire logic             i_reg_wr,
	input  wire logic             i_reg_rd,
	output logic [15:0]           o_reg_rdata,
	// operation request and answer
	input  wire logic             i_op_start,
	input  wire sad_pkg::sad_op_t i_op_code,
	input  wire logic [15:0]      i_opa,
	input  wire logic [15:0]      i_opb,
	input  wire logic [31:0]      i_op_wdata,
	input  wire logic [2:0]       i_bit_disp,
	output logic                  o_op_busy,
	output logic                  o_op_done,
	output logic                  o_op_spec_check,
	output logic [31:0]           o_op_result,
	// main storage, one byte plus parity per cycle
	output logic [15:0]           o_mem_addr,
	output logic [8:0]            o_mem_wdata,
	output logic                  o_mem_wr,
	output logic                  o_mem_rd,
	input  wire logic [8:0]       i_mem_rdata
);
	sad_pkg::sad_state_t state_reg;
	sad_pkg::sad_op_t    op_reg;
	sad_pkg::sad_alu_t   alu_func;
	logic [15:0]         alu_a;
	logic [15:0]         alu_b;
	logic [15:0]         alu_y;
	logic                alu_c;
	logic                alu_v;
	logic                alu_e;
	logic                alu_n;
	logic                alu_z;
	logic [15:0]         lsr_reg;
	logic [15:0]         lsr_next;
	logic [15:0]         psw_reg;
	logic [15:0]         cfg_reg;
	logic [15:0]         addr_reg;
	logic [15:0]         rdata_reg;
	logic [31:0]         acc_reg;
	logic [31:0]         acc_next;
	logic [31:0]         sreg_reg;
	logic [31:0]         st_align;
	logic [31:0]         res_reg;
	logic [8:0]          wdata_reg;
	logic [1:0]          idx_reg;
	logic [1:0]          last_reg;
	logic [1:0]          nb;
	logic [2:0]          bit_reg;
	logic [7:0]          rbyte;
	logic                rd_reg;
	logic                wr_reg;
	logic                done_reg;
	logic                spec_reg;
	logic                busy_reg;
	logic                store_reg;
	logic                accept;
	logic                is_mem;
	logic                is_store;
	logic                spec_now;
	logic                capt;
	logic                par_err;
	logic                final_byte;
	logic                issue_first;
	logic                issue_next;
	logic                imm_done;
	logic                ea_odd;

	assign accept      = (state_reg == sad_pkg::SAD_ST_IDLE) && i_op_start;
	assign capt        = (state_reg == sad_pkg::SAD_ST_CAPT);
	assign rbyte       = i_mem_rdata[7:0];
	assign par_err     = capt && !store_reg && cfg_reg[sad_pkg::CFG_PAR_EN] && !(^i_mem_rdata);
	assign final_byte  = (idx_reg == last_reg) || par_err;
	assign issue_first = accept && is_mem && !spec_now;
	assign issue_next  = capt && !final_byte;
	assign imm_done    = accept && (spec_now || !is_mem);
	assign acc_next    = {acc_reg[23:0], rbyte};
	// low bit of opa+opb taken apart from the alu so the check forms no loop
	assign ea_odd      = i_opa[0] ^ i_opb[0];

	// operand mapping onto the alu; storage and branch ops use it for addresses
	always_comb
	begin
		alu_a    = i_opa;
		alu_b    = i_opb;
		alu_func = sad_pkg::SAD_ALU_ADD;
		// every code past branch touches storage
		is_mem   = (i_op_code > sad_pkg::SAD_OP_BRAN);
		is_store = 1'b0;
		nb       = sad_pkg::LAST_BYTE;
		spec_now = 1'b0;
		st_align = '0;
		case (i_op_code)
			sad_pkg::SAD_OP_SUB:  alu_func = sad_pkg::SAD_ALU_SUB;
			sad_pkg::SAD_OP_AND:  alu_func = sad_pkg::SAD_ALU_AND;
			sad_pkg::SAD_OP_OR:   alu_func = sad_pkg::SAD_ALU_OR;
			sad_pkg::SAD_OP_XOR:  alu_func = sad_pkg::SAD_ALU_XOR;
			sad_pkg::SAD_OP_MOVE: alu_func = sad_pkg::SAD_ALU_PASS;
			sad_pkg::SAD_OP_CMPL: alu_func = sad_pkg::SAD_ALU_NEG;
			sad_pkg::SAD_OP_SEXT: alu_func = sad_pkg::SAD_ALU_SEXT;
			sad_pkg::SAD_OP_ADDR:
			begin
				alu_b    = {i_opb[14:0], 1'b0};
				spec_now = i_opa[0];
			end
			sad_pkg::SAD_OP_BRAN: spec_now = ea_odd;
			sad_pkg::SAD_OP_LDW:
			begin
				nb       = sad_pkg::LAST_WORD;
				spec_now = ea_odd;
			end
			sad_pkg::SAD_OP_LDD:
			begin
				nb       = sad_pkg::LAST_DBL;
				spec_now = ea_odd;
			end
			sad_pkg::SAD_OP_STB:
			begin
				is_store = 1'b1;
				st_align = {i_op_wdata[7:0], 24'h00_0000};
			end
			sad_pkg::SAD_OP_STW:
			begin
				is_store = 1'b1;
				nb       = sad_pkg::LAST_WORD;
				spec_now = ea_odd;
				st_align = {i_op_wdata[15:0], 16'h0000};
			end
			sad_pkg::SAD_OP_STD:
			begin
				is_store = 1'b1;
				nb       = sad_pkg::LAST_DBL;
				spec_now = ea_odd;
				st_align = i_op_wdata;
			end
			default: alu_func = sad_pkg::SAD_ALU_ADD;
		endcase
	end

	sad_alu #(
		.WIDTH (sad_pkg::DATA_W)
	) u_alu (
		.i_func  (alu_func),
		.i_a     (alu_a),
		.i_b     (alu_b),
		.o_y     (alu_y),
		.o_carry (alu_c),
		.o_ovf   (alu_v),
		.o_even  (alu_e),
		.o_neg   (alu_n),
		.o_zero  (alu_z)
	);

	// indicator update for immediate operations
	always_comb
	begin
		lsr_next = lsr_reg;
		case (i_op_code)
			sad_pkg::SAD_OP_ADD, sad_pkg::SAD_OP_SUB:
			begin
				lsr_next[sad_pkg::LSR_CARRY] = alu_c;
				lsr_next[sad_pkg::LSR_OVF]   = alu_v;
			end
			sad_pkg::SAD_OP_CMPL: lsr_next[sad_pkg::LSR_OVF] = alu_v;
			default: lsr_next[sad_pkg::LSR_OVF] = lsr_reg[sad_pkg::LSR_OVF];
		endcase
		if (i_op_code <= sad_pkg::SAD_OP_SEXT)
		begin
			lsr_next[sad_pkg::LSR_EVEN] = alu_e;
			lsr_next[sad_pkg::LSR_NEG]  = alu_n;
			lsr_next[sad_pkg::LSR_ZERO] = alu_z;
		end
	end

	// sequencer: two cycles per byte, issue then capture
	always_ff @(posedge i_clock)
	begin
		if (!i_nrst)
			state_reg <= sad_pkg::SAD_ST_IDLE;
		else
			case (state_reg)
				sad_pkg::SAD_ST_IDLE:
					if (issue_first)
						state_reg <= sad_pkg::SAD_ST_ISSUE;
				sad_pkg::SAD_ST_ISSUE: state_reg <= sad_pkg::SAD_ST_CAPT;
				sad_pkg::SAD_ST_CAPT:
					state_reg <= final_byte ? sad_pkg::SAD_ST_IDLE : sad_pkg::SAD_ST_ISSUE;
				default: state_reg <= sad_pkg::SAD_ST_IDLE;
			endcase
	end

	// operand context held for the storage sequence
	always_ff @(posedge i_clock)
	begin
		if (!i_nrst)
		begin
			op_reg    <= sad_pkg::SAD_OP_ADD;
			store_reg <= 1'b0;
			last_reg  <= sad_pkg::LAST_BYTE;
			bit_reg   <= '0;
			idx_reg   <= sad_pkg::LAST_BYTE;
			acc_reg   <= '0;
		end
		else if (issue_first)
		begin
			op_reg    <= i_op_code;
			store_reg <= is_store;
			last_reg  <= nb;
			bit_reg   <= i_bit_disp;
			idx_reg   <= sad_pkg::LAST_BYTE;
			acc_reg   <= '0;
		end
		else if (capt)
		begin
			acc_reg <= acc_next;
			idx_reg <= idx_reg + 2'h1;
		end
	end

	// storage strobes, address and write byte
	always_ff @(posedge i_clock)
	begin
		if (!i_nrst)
		begin
			rd_reg    <= 1'b0;
			wr_reg    <= 1'b0;
			addr_reg  <= '0;
			wdata_reg <= '0;
			sreg_reg  <= '0;
		end
		else
		begin
			rd_reg <= (issue_first && !is_store) || (issue_next && !store_reg);
			wr_reg <= (issue_first && is_store) || (issue_next && store_reg);
			if (issue_first)
			begin
				addr_reg  <= alu_y;
				wdata_reg <= {~^st_align[31:24], st_align[31:24]};
				sreg_reg  <= {st_align[23:0], 8'h00};
			end
			else if (issue_next)
			begin
				addr_reg  <= addr_reg + sad_pkg::ADDR_STEP;
				wdata_reg <= {~^sreg_reg[31:24], sreg_reg[31:24]};
				sreg_reg  <= {sreg_reg[23:0], 8'h00};
			end
		end
	end

	// answer to the requester
	always_ff @(posedge i_clock)
	begin
		if (!i_nrst)
		begin
			done_reg <= 1'b0;
			spec_reg <= 1'b0;
			busy_reg <= 1'b0;
			res_reg  <= '0;
		end
		else
		begin
			done_reg <= imm_done || (capt && final_byte);
			spec_reg <= accept && spec_now;
			busy_reg <= issue_first || issue_next || (state_reg == sad_pkg::SAD_ST_ISSUE);
			if (imm_done)
				res_reg <= spec_now ? '0 : {16'h0000, alu_y};
			else if (capt && final_byte)
				if (op_reg == sad_pkg::SAD_OP_BTST)
					res_reg <= {31'h0000_0000, rbyte[3'(sad_pkg::BYTE_W-1) - bit_reg]};
				else if (store_reg)
					res_reg <= '0;
				else
					res_reg <= acc_next;
		end
	end

	// level status register; hardware update wins over a software write
	always_ff @(posedge i_clock)
	begin
		if (!i_nrst)
			lsr_reg <= sad_pkg::LSR_RESET;
		else if (imm_done && !spec_now)
			lsr_reg <= lsr_next;
		else if (capt && final_byte && !par_err && !store_reg && op_reg != sad_pkg::SAD_OP_LDD
			&& op_reg != sad_pkg::SAD_OP_BTST)
		begin
			lsr_reg[sad_pkg::LSR_EVEN] <= ~acc_next[0];
			lsr_reg[sad_pkg::LSR_NEG]  <= acc_next[15];
			lsr_reg[sad_pkg::LSR_ZERO] <= (acc_next[15:0] == 16'h0000);
		end
		else if (i_reg_wr && i_reg_addr == sad_pkg::REG_LSR)
			lsr_reg <= i_reg_wdata & sad_pkg::LSR_MASK;
	end

	// status word: write one to clear, a new event wins over the clear
	always_ff @(posedge i_clock)
	begin
		if (!i_nrst)
			psw_reg <= sad_pkg::PSW_RESET;
		else
		begin
			psw_reg <= (psw_reg & ~((i_reg_wr && i_reg_addr == sad_pkg::REG_PSW) ?
				i_reg_wdata : 16'h0000)) & sad_pkg::PSW_MASK;
			if (accept && spec_now)
				psw_reg[sad_pkg::PSW_SPEC] <= 1'b1;
			if (par_err)
				psw_reg[sad_pkg::PSW_PAR] <= 1'b1;
		end
	end

	// configuration and register read port
	always_ff @(posedge i_clock)
	begin
		if (!i_nrst)
		begin
			cfg_reg   <= sad_pkg::CFG_RESET;
			rdata_reg <= '0;
		end
		else
		begin
			if (i_reg_wr && i_reg_addr == sad_pkg::REG_CFG)
				cfg_reg <= i_reg_wdata & sad_pkg::CFG_MASK;
			rdata_reg <= '0;
			if (i_reg_rd)
				case (i_reg_addr)
					sad_pkg::REG_LSR: rdata_reg <= lsr_reg;
					sad_pkg::REG_PSW: rdata_reg <= psw_reg;
					sad_pkg::REG_SAR: rdata_reg <= addr_reg;
					sad_pkg::REG_CFG: rdata_reg <= cfg_reg;
					default:          rdata_reg <= '0;
				endcase
		end
	end

	assign o_reg_rdata     = rdata_reg;
	assign o_op_busy       = busy_reg;
	assign o_op_done       = done_reg;
	assign o_op_spec_check = spec_reg;
	assign o_op_result     = res_reg;
	assign o_mem_addr      = addr_reg;
	assign o_mem_wdata     = wdata_reg;
	assign o_mem_wr        = wr_reg;
	assign o_mem_rd        = rd_reg;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_nrst);

	property p_par_write;
		wr_reg |-> (^wdata_reg);
	endproperty
	a_par_write: assert property (p_par_write)
		else $error("storage write byte has even parity");

	property p_par_check;
		(capt && !store_reg && cfg_reg[sad_pkg::CFG_PAR_EN] && !(^i_mem_rdata))
			|=> psw_reg[sad_pkg::PSW_PAR] && done_reg;
	endproperty
	a_par_check: assert property (p_par_check)
		else $error("even parity read not flagged");

	property p_spec_term;
		(accept && spec_now) |=> spec_reg && done_reg && !rd_reg && !wr_reg
			&& psw_reg[sad_pkg::PSW_SPEC] ##1 !rd_reg && !wr_reg;
	endproperty
	a_spec_term: assert property (p_spec_term)
		else $error("misaligned operation touched storage or was not flagged");

	property p_branch_even;
		(accept && i_op_code == sad_pkg::SAD_OP_BRAN && (i_opa[0] ^ i_opb[0])) |=> spec_reg;
	endproperty
	a_branch_even: assert property (p_branch_even)
		else $error("odd branch target accepted");

	property p_word_even;
		((rd_reg || wr_reg) && idx_reg == sad_pkg::LAST_BYTE && last_reg != sad_pkg::LAST_BYTE)
			|-> !addr_reg[0];
	endproperty
	a_word_even: assert property (p_word_even)
		else $error("word or doubleword started on odd address");

	property p_wrap;
		(capt && !final_byte) |=> addr_reg == $past(addr_reg) + sad_pkg::ADDR_STEP;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("next byte address not previous plus one modulo 65536");

	property p_add_carry;
		(accept && i_op_code == sad_pkg::SAD_OP_ADD) |=> lsr_reg[sad_pkg::LSR_CARRY] ==
			(({1'b0, $past(i_opa)} + {1'b0, $past(i_opb)}) > 17'h0_ffff);
	endproperty
	a_add_carry: assert property (p_add_carry)
		else $error("carry does not match unsigned overflow");

	property p_cmpl_ovf;
		(accept && i_op_code == sad_pkg::SAD_OP_CMPL && i_opa == 16'h8000)
			|=> lsr_reg[sad_pkg::LSR_OVF] && o_op_result[15:0] == 16'h8000;
	endproperty
	a_cmpl_ovf: assert property (p_cmpl_ovf)
		else $error("complement of most negative did not set overflow");

	property p_done_bound;
		accept |-> ##[1:9] done_reg;
	endproperty
	a_done_bound: assert property (p_done_bound)
		else $error("operation did not finish within nine cycles");

	c_spec: cover property (accept && spec_now ##1 spec_reg);
	c_dbl_load: cover property (issue_first && i_op_code == sad_pkg::SAD_OP_LDD ##9 done_reg);
	c_par_err: cover property (par_err);
	c_wrap: cover property (wr_reg && addr_reg == 16'h0000 && idx_reg != sad_pkg::LAST_BYTE);
endmodule // sad_core

// [testbench/sad_mem_model.sv]
// main storage array model: one byte plus parity per cycle
`timescale 1ns/10ps
module sad_mem_model (
	// clock
	input  wire logic        i_clock,
	// storage port of the core
	input  wire logic [15:0] i_addr,
	input  wire logic [8:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	// test control: corrupt parity on reads
	input  wire logic        i_flip,
	// read data
	output logic [8:0]       o_rdata
);
	logic [8:0] mem_reg [0:65535];
	initial
	begin
		o_rdata = 9'h000;
	end
	always @(posedge i_clock)
	begin
		if (i_wr)
			mem_reg[i_addr] <= i_wdata;
		// data stand one cycle only; toggling keeps a stale byte from passing
		o_rdata <= i_rd ? (mem_reg[i_addr] ^ {i_flip, 8'h00}) : ~o_rdata;
	end
endmodule // sad_mem_model

// [testbench/tb_top.sv]
// self-checking testbench for the storage addressing datapath
`timescale 1ns/10ps
module tb_top;
	localparam logic [31:0] LO  = 32'h0000_ffff;
	localparam logic [31:0] ALL = 32'hffff_ffff;
	logic             i_clock;
	logic             i_nrst;
	logic [7:0]       i_reg_addr;
	logic [15:0]      i_reg_wdata;
	logic             i_reg_wr;
	logic             i_reg_rd;
	logic [15:0]      o_reg_rdata;
	logic             i_op_start;
	sad_pkg::sad_op_t i_op_code;
	logic [15:0]      i_opa;
	logic [15:0]      i_opb;
	logic [31:0]      i_op_wdata;
	logic [2:0]       i_bit_disp;
	logic             o_op_busy;
	logic             o_op_done;
	logic             o_op_spec_check;
	logic [31:0]      o_op_result;
	logic [15:0]      o_mem_addr;
	logic [8:0]       o_mem_wdata;
	logic             o_mem_wr;
	logic             o_mem_rd;
	logic [8:0]       i_mem_rdata;
	logic             i_flip;
	int               fails;
	int               total_checks;
	int               strobes;
	int               cycles;

	sad_core u_dut (
		.i_clock(i_clock), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr),
		.i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
		.o_reg_rdata(o_reg_rdata), .i_op_start(i_op_start), .i_op_code(i_op_code),
		.i_opa(i_opa), .i_opb(i_opb), .i_op_wdata(i_op_wdata), .i_bit_disp(i_bit_disp),
		.o_op_busy(o_op_busy), .o_op_done(o_op_done), .o_op_spec_check(o_op_spec_check),
		.o_op_result(o_op_result), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
		.o_mem_wr(o_mem_wr), .o_mem_rd(o_mem_rd), .i_mem_rdata(i_mem_rdata)
	);
	sad_mem_model u_mem (
		.i_clock(i_clock), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_wr(o_mem_wr),
		.i_rd(o_mem_rd), .i_flip(i_flip), .o_rdata(i_mem_rdata)
	);

	initial
	begin
		i_clock = 1'b0;
		forever
			#50 i_clock = ~i_clock;
	end

	// storage strobes seen, and a ceiling on run length
	always @(posedge i_clock)
	begin
		if (o_mem_rd === 1'b1 || o_mem_wr === 1'b1)
			strobes++;
		cycles++;
		if (cycles == 3000)
		begin
			fails++;
			results();
		end
	end

	task automatic results();
		begin
			$display("checks %0d mismatches %0d", total_checks, fails);
			if (fails == 0 && total_checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask

	task automatic check(input logic [31:0] g, input logic [31:0] e);
		begin
			total_checks++;
			if (g !== e)
			begin
				fails++;
				$display("Error at %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask

	task automatic rw(input logic [7:0] a, input logic [15:0] d);
		begin
			i_reg_wr    <= 1'b1;
			i_reg_addr  <= a;
			i_reg_wdata <= d;
			@(posedge i_clock);
			i_reg_wr <= 1'b0;
			#1;
		end
	endtask

	task automatic rr(input logic [7:0] a, input logic [15:0] e);
		begin
			i_reg_rd   <= 1'b1;
			i_reg_addr <= a;
			@(posedge i_clock);
			i_reg_rd <= 1'b0;
			#1;
			check({16'h0000, o_reg_rdata}, {16'h0000, e});
		end
	endtask

	task automatic op(input sad_pkg::sad_op_t c, input logic [15:0] a, input logic [15:0] b,
		input logic [31:0] wd, input logic [31:0] er, input logic [31:0] m, input logic es,
		input int lat);
		int n;
		begin
			i_op_start <= 1'b1;
			i_op_code  <= c;
			i_opa      <= a;
			i_opb      <= b;
			i_op_wdata <= wd;
			strobes = 0;
			n = 0;
			// done stands one cycle: look right after every edge, the start edge too
			do
			begin
				@(posedge i_clock);
				i_op_start <= 1'b0;
				#1;
				n++;
				if (o_op_done !== 1'b1)
					check({31'h0, o_op_busy}, 32'h1);
			end while (o_op_done !== 1'b1 && n < 12);
			check(n, lat);
			check({31'h0, o_op_busy}, 32'h0);
			check(o_op_result & m, er & m);
			check({31'h0, o_op_spec_check}, {31'h0, es});
			if (es)
			begin
				// a wrong strobe would show one edge after the start edge
				@(posedge i_clock);
				#1;
				check(strobes, 0);
			end
		end
	endtask

	task automatic alu(input sad_pkg::sad_op_t c, input logic [15:0] a, input logic [15:0] b,
		input logic [15:0] y, input logic [15:0] l);
		begin
			op(c, a, b, 32'h0, {16'h0, y}, LO, 1'b0, 1);
			rr(sad_pkg::REG_LSR, l);
		end
	endtask

	initial
	begin
		logic [31:0] d;
		logic [7:0]  v;
		logic [7:0]  bt;
		d = 32'h1234_5678;
		v = 8'ha5;
		{fails, total_checks, strobes, cycles} = '0;
		{i_nrst, i_reg_wr, i_reg_rd, i_op_start, i_flip} = '0;
		{i_reg_addr, i_reg_wdata, i_opa, i_opb, i_op_wdata, i_bit_disp} = '0;
		i_op_code = sad_pkg::SAD_OP_ADD;
		repeat (8) @(posedge i_clock);
		i_nrst <= 1'b1;
		@(posedge i_clock);
		#1;
		rr(sad_pkg::REG_LSR, sad_pkg::LSR_RESET);
		rr(sad_pkg::REG_PSW, sad_pkg::PSW_RESET);
		rr(sad_pkg::REG_CFG, sad_pkg::CFG_RESET);
		rr(8'h10, 16'h0000);
		alu(sad_pkg::SAD_OP_ADD, 16'h7fff, 16'h0001, 16'h8000, 16'hb000);
		alu(sad_pkg::SAD_OP_ADD, 16'hffff, 16'h0001, 16'h0000, 16'hc800);
		alu(sad_pkg::SAD_OP_SUB, 16'h0000, 16'h0001, 16'hffff, 16'h5000);
		alu(sad_pkg::SAD_OP_SUB, 16'h8000, 16'h0001, 16'h7fff, 16'h2000);
		alu(sad_pkg::SAD_OP_AND, 16'hf0f0, 16'h0ff0, 16'h00f0, 16'ha000);
		alu(sad_pkg::SAD_OP_OR, 16'h1200, 16'h0034, 16'h1234, 16'ha000);
		alu(sad_pkg::SAD_OP_XOR, 16'hffff, 16'hffff, 16'h0000, 16'ha800);
		alu(sad_pkg::SAD_OP_ADD, 16'h0001, 16'h0001, 16'h0002, 16'h8000);
		alu(sad_pkg::SAD_OP_CMPL, 16'h8000, 16'h0000, 16'h8000, 16'hb000);
		alu(sad_pkg::SAD_OP_CMPL, 16'h0001, 16'h0000, 16'hffff, 16'h1000);
		alu(sad_pkg::SAD_OP_SEXT, 16'h0080, 16'h0000, 16'hff80, 16'h9000);
		alu(sad_pkg::SAD_OP_SEXT, 16'h007f, 16'h0000, 16'h007f, 16'h0000);
		alu(sad_pkg::SAD_OP_MOVE, 16'h0000, 16'h0000, 16'h0000, 16'h8800);
		op(sad_pkg::SAD_OP_ADDR, 16'hfffe, 16'h0002, 0, 32'h2, LO, 0, 1);
		op(sad_pkg::SAD_OP_ADDR, 16'h0003, 16'h0001, 0, 0, ALL, 1, 1);
		rr(sad_pkg::REG_PSW, 16'h4000);
		rw(sad_pkg::REG_PSW, 16'h4000);
		rr(sad_pkg::REG_PSW, 16'h0000);
		op(sad_pkg::SAD_OP_BRAN, 16'h1000, 16'h0010, 0, 32'h1010, LO, 0, 1);
		op(sad_pkg::SAD_OP_BRAN, 16'h1000, 16'h0003, 0, 0, ALL, 1, 1);
		op(sad_pkg::SAD_OP_STW, 16'h0000, 16'h0001, 32'hbeef, 0, ALL, 1, 1);
		op(sad_pkg::SAD_OP_LDD, 16'h0001, 16'h0002, 0, 0, ALL, 1, 1);
		rr(sad_pkg::REG_LSR, 16'h8800);
		rw(sad_pkg::REG_PSW, 16'h6000);
		op(sad_pkg::SAD_OP_STD, 16'hfffc, 16'h0002, d, 0, 0, 0, 9);
		for (int i = 0; i < 4; i++)
		begin
			bt = d[31-8*i -: 8];
			check({23'h0, u_mem.mem_reg[16'hfffe + i[15:0]]}, {23'h0, ~^bt, bt});
		end
		op(sad_pkg::SAD_OP_LDD, 16'hfffc, 16'h0002, 0, d, ALL, 0, 9);
		rr(sad_pkg::REG_SAR, 16'h0001);
		op(sad_pkg::SAD_OP_LDW, 16'h0000, 16'h0000, 0, 32'h5678, ALL, 0, 5);
		rr(sad_pkg::REG_LSR, 16'h8000);
		op(sad_pkg::SAD_OP_LDB, 16'hffff, 16'h0000, 0, 32'h34, ALL, 0, 3);
		op(sad_pkg::SAD_OP_STB, 16'h0004, 16'h0001, {24'h0, v}, 0, 0, 0, 3);
		for (int i = 0; i < 8; i++)
		begin
			i_bit_disp <= i[2:0];
			op(sad_pkg::SAD_OP_BTST, 16'h0005, 16'h0000, 0, {31'h0, v[7-i]}, 1, 0, 3);
		end
		i_flip <= 1'b1;
		op(sad_pkg::SAD_OP_LDB, 16'h0005, 16'h0000, 0, 0, 0, 0, 3);
		rr(sad_pkg::REG_PSW, 16'h2000);
		rw(sad_pkg::REG_PSW, 16'h6000);
		rw(sad_pkg::REG_CFG, 16'h0000);
		op(sad_pkg::SAD_OP_LDB, 16'h0005, 16'h0000, 0, {24'h0, v}, ALL, 0, 3);
		rr(sad_pkg::REG_PSW, 16'h0000);
		i_flip <= 1'b0;
		rw(sad_pkg::REG_CFG, 16'h0001);
		rw(sad_pkg::REG_LSR, 16'hffff);
		rr(sad_pkg::REG_LSR, 16'hf800);
		rw(8'h10, 16'h1234);
		rr(8'h10, 16'h0000);
		results();
	end
endmodule // tb_top
